// *** inc/bio_pkg.sv ***
package bio_pkg;
    // ------------------------------------------------------------
    // clock and fail-safe timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned FAILSAFE_MS = 10;
    localparam int unsigned FAILSAFE_CYC = FAILSAFE_MS * (CLK_HZ / 1000);
    // ------------------------------------------------------------
    // address line positions: cpu_addr[n] carries line A(13-n)
    // ------------------------------------------------------------
    localparam int ADR_A1 = 12;
    localparam int ADR_BLK_MSB = 11;
    localparam int ADR_BLK_LSB = 10;
    localparam int ADR_GAP_MSB = 9;
    localparam int ADR_GAP_LSB = 6;
    localparam int ADR_BIT_MSB = 5;
    localparam int ADR_BIT_LSB = 1;
    localparam int IO_BITS = 2048;
    // ------------------------------------------------------------
    // port bit map and pin sharing
    // ------------------------------------------------------------
    localparam logic [4:0] PBIT_CTRL = 5'h00;
    localparam int PORT_PINS = 16;
    localparam int SHARED_LO = 7;
    localparam int SHARED_SUM = 22;
    // ------------------------------------------------------------
    // system port output fields
    // ------------------------------------------------------------
    localparam int SP_DIGIT_LSB = 0;
    localparam int SP_SEG_LSB = 4;
    localparam int SP_KEEP = 12;
    localparam int SP_SHIFT = 13;
    localparam int SP_SPKR = 14;
    localparam int SP_TAPE = 15;
    localparam int DIGITS = 10;
    localparam int KEY_ROWS = 9;
    localparam int KEY_COLS = 5;
    localparam int LEDS = 4;
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_USER_PINS = 8'h08;
    localparam logic [7:0] OFS_SYS_PINS = 8'h0C;
    localparam logic [7:0] OFS_IOADDR = 8'h10;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam int CTRL_BLANK = 0;
    localparam int ST_DISP_OFF = 0;
    localparam int ST_UPEND = 1;
    localparam int ST_SPEND = 2;
    localparam int ST_TAPE = 3;
    localparam int ST_KEY_LSB = 4;
    typedef enum logic [1:0] {
        BLK_USER = 2'b00,
        BLK_SYS = 2'b01,
        BLK_SER = 2'b10,
        BLK_EXT = 2'b11
    } bio_block_t;
    typedef struct packed {
        logic [13:0] addr;
        logic cycle;
        logic strobe;
        logic dout;
        logic ext_in;
        logic [5:1] uint_n;
        logic [15:0] upin;
        logic [4:0] col_n;
        logic audio;
    } bio_pins_t;
endpackage

// *** verilog/bio_port.sv ***
module bio_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sel,
    input wire logic [4:0] bit_idx,
    input wire logic wr_stb,
    input wire logic wr_bit,
    input wire logic [6:1] int_in_n,
    input wire logic [15:0] pin_in,
    output logic rd_bit,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    output logic int_pend_n
);
    logic ctrl_r;
    logic [15:1] mask_r;
    logic [15:0] out_r;
    logic [15:0] oe_r;
    logic pend_n_r;
    logic [15:1] line_n;
    logic [15:1] act;
    logic [15:0] pin_rd;
    logic [31:0] rd_vec;
    wire wr = sel & wr_stb;

    // ------------------------------------------------------------
    // interrupt lines, dedicated and shared with pins
    // ------------------------------------------------------------
    genvar k;
    for (k = 1; k < 16; k++)
    begin : g_int
        if (k < bio_pkg::SHARED_LO)
        begin : g_ded
            assign line_n[k] = int_in_n[k];
            assign act[k] = ~line_n[k] & mask_r[k];
        end
        else
        begin : g_shr
            assign line_n[k] = pin_in[bio_pkg::SHARED_SUM - k];
            // a pin driven as output cannot raise its own interrupt
            assign act[k] = ~line_n[k] & mask_r[k] & ~oe_r[bio_pkg::SHARED_SUM - k]; // [R22]
        end
    end

    // ------------------------------------------------------------
    // bit read and write
    // ------------------------------------------------------------
    // masked lines stay readable as plain inputs
    assign pin_rd = (out_r & oe_r) | (pin_in & ~oe_r);
    assign rd_vec = {pin_rd, pend_n_r, line_n[14:1], ctrl_r}; // [R16]
    assign rd_bit = rd_vec[bit_idx];
    assign pin_out = out_r;
    assign pin_oe = oe_r;
    assign int_pend_n = pend_n_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= 1'b0;
            mask_r <= '0;
            out_r <= '0;
            oe_r <= '0;
            pend_n_r <= 1'b1;
        end
        else
        begin
            pend_n_r <= ~|act;
            if (wr)
            begin
                if (bit_idx == bio_pkg::PBIT_CTRL)
                    ctrl_r <= wr_bit;
                else if (!bit_idx[4])
                    mask_r[bit_idx[3:0]] <= wr_bit;
                else
                begin
                    // first write to a pin turns it into an output
                    out_r[bit_idx[3:0]] <= wr_bit; // [R6]
                    oe_r[bit_idx[3:0]] <= 1'b1;
                end
            end
        end
    end
endmodule

// *** verilog/bio_top.sv ***
// Overview of operation
// [R1] bit-serial space holds 2048 bits; each strobe moves one bit of a 1-16 bit transfer
// [R2] bit address on A2..A12 equals the base register value shifted right once
// [R3] four 32-bit blocks: user, system, serial, external, each with its own enable
// [R4] space enable only while A1 and A4..A7 are low, each block mapped once
// [R5] A8..A12 pick the bit in a port; A2,A3 pick the block under space enable
// [R6] user port gives 16 bidirectional lines
// [R7] user output bits 0..3 also light four LEDs when one
// [R8] system port sits at software addresses 400..43E
// [R9] ten display digits are used, numbered 1 to 10
// [R10] segment sourced only when its low output and low display enable coincide
// [R11] four-bit code decodes to ten low digit enables, zero selects digit 1
// [R12] software pulses keepalive line periodically while in control
// [R13] missing keepalive pulses let fail-safe expire and blank the display
// [R14] keyboard is 45 keys, 9 rows by 5 columns
// [R15] digit enables 1..9 drive rows; low pulled-up column means key closed
// [R16] masked interrupt inputs read as plain inputs; columns via inputs 1..5
// [R17] tape data: zero two cycles 1200 Hz, one two cycles 2400 Hz
// [R18] software writes tape square wave on system output bit 15
// [R19] squared tape read data keeps the audio polarity
// [R20] speaker follows system output bit 14
// [R21] system outputs: 0-3 digit code, 4-11 segments, 12 keepalive, 13 shift
// [R22] shared interrupt pins ignore interrupts while driven as outputs
module bio_top #(
    parameter int unsigned FAILSAFE_CYCLES = bio_pkg::FAILSAFE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [13:0] cpu_addr,
    input wire logic io_cycle,
    input wire logic io_strobe,
    input wire logic io_out_bit,
    output logic io_in_bit,
    output logic io_space_enable_n,
    output logic user_port_select_n,
    output logic system_port_select_n,
    output logic serial_port_select_n,
    output logic external_io_select,
    input wire logic ext_io_in,
    input wire logic [5:1] user_int_n,
    input wire logic [15:0] user_pin_in,
    output logic [15:0] user_pin_out,
    output logic [15:0] user_pin_oe,
    output logic [3:0] user_led,
    input wire logic [4:0] key_column_n,
    output logic [8:0] key_row_n,
    output logic [9:0] digit_enable_n,
    output logic [7:0] segment_drive,
    output logic display_enable_n,
    output logic shift_indicator,
    output logic speaker_drive,
    output logic tape_write_data,
    input wire logic tape_audio_in
);
    localparam int CW = $clog2(FAILSAFE_CYCLES + 1);
    localparam logic [CW-1:0] FS_LOAD = CW'(FAILSAFE_CYCLES);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (FAILSAFE_CYCLES < 2)
    begin : g_chk
        $error("FAILSAFE_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    bio_pkg::bio_pins_t raw;
    bio_pkg::bio_pins_t s1_r;
    bio_pkg::bio_pins_t s2_r;

    assign raw = {cpu_addr, io_cycle, io_strobe, io_out_bit, ext_io_in,
                  user_int_n, user_pin_in, key_column_n, tape_audio_in};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end

    // ------------------------------------------------------------
    // bit-serial address decode
    // ------------------------------------------------------------
    logic stb_d_r;
    wire stb_rise = s2_r.strobe & ~stb_d_r;
    // 11 address lines reach every one of the bits
    wire [10:0] bit_addr = s2_r.addr[bio_pkg::ADR_BLK_MSB:bio_pkg::ADR_BIT_LSB]; // [R1]
    // base register view is the bit address with a zero below it
    wire [11:0] base_view = {bit_addr, 1'b0}; // [R2]
    wire gap_low = ~s2_r.addr[bio_pkg::ADR_A1]
                   & ~|s2_r.addr[bio_pkg::ADR_GAP_MSB:bio_pkg::ADR_GAP_LSB];
    wire io_en = s2_r.cycle & gap_low; // [R4]
    wire [4:0] bit_idx = s2_r.addr[bio_pkg::ADR_BIT_MSB:bio_pkg::ADR_BIT_LSB]; // [R5]
    bio_pkg::bio_block_t blk;
    assign blk = bio_pkg::bio_block_t'(s2_r.addr[bio_pkg::ADR_BLK_MSB:bio_pkg::ADR_BLK_LSB]); // [R5]
    wire sel_user = io_en & (blk == bio_pkg::BLK_USER); // [R3]
    // system port answers at software base 400, block code 01
    wire sel_sys = io_en & (blk == bio_pkg::BLK_SYS); // [R3] [R8]
    wire sel_ser = io_en & (blk == bio_pkg::BLK_SER); // [R3]
    wire sel_ext = io_en & (blk == bio_pkg::BLK_EXT); // [R3]

    // ------------------------------------------------------------
    // user and system ports
    // ------------------------------------------------------------
    logic user_rd;
    logic sys_rd;
    logic user_pend_n;
    logic sys_pend_n;
    logic [15:0] sys_out;
    logic [15:0] sys_oe;
    logic [15:0] sys_lvl;

    // undriven system pins float high through pull-ups
    assign sys_lvl = sys_out | ~sys_oe;

    bio_port u_user (
        .clk(pclk),
        .rst_n(presetn),
        .sel(sel_user),
        .bit_idx(bit_idx),
        .wr_stb(stb_rise),
        .wr_bit(s2_r.dout),
        .int_in_n({sys_pend_n, s2_r.uint_n}),
        .pin_in(s2_r.upin),
        .rd_bit(user_rd),
        .pin_out(user_pin_out),
        .pin_oe(user_pin_oe),
        .int_pend_n(user_pend_n)
    );

    // columns on inputs 1..5, squared tape data on input 6
    bio_port u_sys (
        .clk(pclk),
        .rst_n(presetn),
        .sel(sel_sys),
        .bit_idx(bit_idx),
        .wr_stb(stb_rise),
        .wr_bit(s2_r.dout),
        .int_in_n({s2_r.audio, s2_r.col_n}), // [R16] [R19]
        .pin_in(sys_lvl),
        .rd_bit(sys_rd),
        .pin_out(sys_out),
        .pin_oe(sys_oe),
        .int_pend_n(sys_pend_n)
    );

    // ------------------------------------------------------------
    // read-back and enables toward the processor
    // ------------------------------------------------------------
    logic in_nxt;

    always_comb
    begin
        case (blk)
            bio_pkg::BLK_USER: in_nxt = user_rd;
            bio_pkg::BLK_SYS: in_nxt = sys_rd;
            bio_pkg::BLK_EXT: in_nxt = s2_r.ext_in;
            default: in_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stb_d_r <= 1'b0;
            io_in_bit <= 1'b0;
            io_space_enable_n <= 1'b1;
            user_port_select_n <= 1'b1;
            system_port_select_n <= 1'b1;
            serial_port_select_n <= 1'b1;
            external_io_select <= 1'b0;
        end
        else
        begin
            stb_d_r <= s2_r.strobe;
            io_in_bit <= io_en & in_nxt;
            io_space_enable_n <= ~io_en; // [R4]
            user_port_select_n <= ~sel_user; // [R3]
            system_port_select_n <= ~sel_sys;
            serial_port_select_n <= ~sel_ser;
            external_io_select <= sel_ext;
        end
    end

    // ------------------------------------------------------------
    // display, keyboard rows and fail-safe
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [CW-1:0] fs_cnt_r;
    logic keep_d_r;
    logic [9:0] digit_nxt;
    // output field map of the system port
    wire [3:0] digit_code = sys_lvl[bio_pkg::SP_DIGIT_LSB +: 4]; // [R21]
    wire [7:0] seg_n = sys_lvl[bio_pkg::SP_SEG_LSB +: 8]; // [R21]
    wire keep_n = sys_lvl[bio_pkg::SP_KEEP]; // [R21]
    // a falling edge of the keepalive line proves software is alive
    wire keep_fall = keep_d_r & ~keep_n; // [R12]
    wire fs_expired = (fs_cnt_r == '0);
    wire disp_off = fs_expired | ctrl_r[bio_pkg::CTRL_BLANK]; // [R13]

    genvar d;
    for (d = 0; d < bio_pkg::DIGITS; d++)
    begin : g_digit
        // codes ten and above leave every digit dark
        assign digit_nxt[d] = ~(digit_code == 4'(d)); // [R9] [R11]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            keep_d_r <= 1'b1;
            fs_cnt_r <= '0;
        end
        else
        begin
            keep_d_r <= keep_n;
            // segment currents are high, so a stalled scan must blank quickly
            if (keep_fall)
                fs_cnt_r <= FS_LOAD; // [R13]
            else if (!fs_expired)
                fs_cnt_r <= fs_cnt_r - 1'b1; // [R13]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            digit_enable_n <= '1;
            key_row_n <= '1;
            segment_drive <= '0;
            display_enable_n <= 1'b1;
            shift_indicator <= 1'b0;
            speaker_drive <= 1'b0;
            tape_write_data <= 1'b0;
            user_led <= '0;
        end
        else
        begin
            digit_enable_n <= digit_nxt; // [R11]
            // rows share the first nine digit enables
            key_row_n <= digit_nxt[bio_pkg::KEY_ROWS-1:0]; // [R14] [R15]
            segment_drive <= ~seg_n & {8{~disp_off}}; // [R10]
            display_enable_n <= disp_off; // [R13]
            shift_indicator <= sys_lvl[bio_pkg::SP_SHIFT]; // [R21]
            speaker_drive <= sys_lvl[bio_pkg::SP_SPKR]; // [R20]
            // frequency coding is left to software
            tape_write_data <= sys_lvl[bio_pkg::SP_TAPE]; // [R17] [R18]
            user_led <= user_pin_out[bio_pkg::LEDS-1:0] & user_pin_oe[bio_pkg::LEDS-1:0]; // [R7]
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    wire acc = psel & penable & ~pready;
    wire hit_ctrl = (paddr == bio_pkg::OFS_CTRL);
    wire hit_stat = (paddr == bio_pkg::OFS_STATUS);
    wire hit_upin = (paddr == bio_pkg::OFS_USER_PINS);
    wire hit_spin = (paddr == bio_pkg::OFS_SYS_PINS);
    wire hit_addr = (paddr == bio_pkg::OFS_IOADDR);
    wire hit_any = hit_ctrl | hit_stat | hit_upin | hit_spin | hit_addr;
    // a key reads as one when its column is pulled low
    wire [31:0] status = {23'h000000, ~s2_r.col_n, s2_r.audio, // [R15]
                          ~sys_pend_n, ~user_pend_n, disp_off};
    logic [31:0] rd_nxt;

    always_comb
    begin
        rd_nxt = 32'h00000000;
        if (hit_ctrl)
            rd_nxt = ctrl_r;
        if (hit_stat)
            rd_nxt = status;
        if (hit_upin)
            rd_nxt = {user_pin_oe, user_pin_out};
        if (hit_spin)
            rd_nxt = {sys_oe, sys_out};
        if (hit_addr)
            rd_nxt = {4'h0, base_view, 5'h00, bit_addr};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= bio_pkg::CTRL_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= acc;
            pslverr <= acc & ~hit_any;
            if (acc & ~pwrite)
                prdata <= rd_nxt;
            if (acc & pwrite & hit_ctrl)
                ctrl_r <= {31'h00000000, pwdata[bio_pkg::CTRL_BLANK]};
        end
    end
endmodule

// *** tb/bio_top_checker.sv ***
module bio_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [13:0] cpu_addr,
    input wire logic io_cycle,
    input wire logic io_in_bit,
    input wire logic io_space_enable_n,
    input wire logic user_port_select_n,
    input wire logic system_port_select_n,
    input wire logic serial_port_select_n,
    input wire logic external_io_select,
    input wire logic [15:0] user_pin_out,
    input wire logic [15:0] user_pin_oe,
    input wire logic [3:0] user_led,
    input wire logic [8:0] key_row_n,
    input wire logic [9:0] digit_enable_n,
    input wire logic [7:0] segment_drive,
    input wire logic display_enable_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------
    // decode
    // --------
    a_one_block: assert property ($onehot0({!user_port_select_n, !system_port_select_n,
        !serial_port_select_n, external_io_select})) else $error("two selects");
    a_sel_space: assert property ((!user_port_select_n || !system_port_select_n || !serial_port_select_n
        || external_io_select) |-> !io_space_enable_n) else $error("select without space");
    // three edges from pin to enable, so four samples
    a_gap_off: assert property ((!io_cycle || cpu_addr[12] || (cpu_addr[9:6] != 4'h0))[*4]
        |=> io_space_enable_n) else $error("space enabled in gap");
    a_ser_zero: assert property (!serial_port_select_n[*2] |-> !io_in_bit)
        else $error("serial read nonzero");
    // --------
    // display, keys, leds
    // --------
    a_digit_one: assert property ($countones(~digit_enable_n) <= 1)
        else $error("two digits on");
    a_row_tie: assert property ($stable(digit_enable_n) |-> key_row_n == digit_enable_n[8:0])
        else $error("rows differ");
    a_led_tie: assert property ($stable(user_pin_out) && $stable(user_pin_oe)
        |-> user_led == (user_pin_out[3:0] & user_pin_oe[3:0])) else $error("leds differ");
    a_seg_dark: assert property (display_enable_n[*2] |-> segment_drive == 8'h00)
        else $error("segment lit while off");
    a_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
    c_disp_on: cover property (!display_enable_n);
    c_slverr: cover property (pslverr);
    c_ext_sel: cover property (external_io_select);
endmodule

bind bio_top bio_top_checker u_bio_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .cpu_addr(cpu_addr), .io_cycle(io_cycle), .io_in_bit(io_in_bit),
    .io_space_enable_n(io_space_enable_n), .user_port_select_n(user_port_select_n),
    .system_port_select_n(system_port_select_n), .serial_port_select_n(serial_port_select_n),
    .external_io_select(external_io_select), .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe),
    .user_led(user_led), .key_row_n(key_row_n), .digit_enable_n(digit_enable_n),
    .segment_drive(segment_drive), .display_enable_n(display_enable_n));

// *** tb/bio_cpu_model.sv ***
module bio_cpu_model (
    input wire logic clk,
    input wire logic io_in_bit,
    output logic [13:0] cpu_addr,
    output logic io_cycle,
    output logic io_strobe,
    output logic io_out_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        {cpu_addr, io_cycle, io_strobe, io_out_bit} = '0;
    end
    // bit address is the base without bit 0
    task automatic put(input logic [11:0] sw, input logic d);
        @(posedge clk);
        cpu_addr <= {2'h0, sw[11:1], 1'h0};
        io_cycle <= 1'h1;
        io_out_bit <= d;
        repeat (4) @(posedge clk);
    endtask
    // released lines show the inverse of their last value
    task automatic rel();
        io_cycle <= 1'h0;
        cpu_addr <= ~cpu_addr;
        io_out_bit <= ~io_out_bit;
    endtask
    task automatic wr(input logic [11:0] sw, input logic d);
        put(sw, d);
        io_strobe <= 1'h1;
        repeat (3) @(posedge clk);
        io_strobe <= 1'h0;
        repeat (4) @(posedge clk);
        rel();
    endtask
    // leaves the cycle open for later decode checks
    task automatic rd(input logic [11:0] sw, output logic d);
        put(sw, ~io_out_bit);
        d = io_in_bit;
    endtask
endmodule

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned FS = 64;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e, b;
    logic [7:0] paddr, segment_drive;
    logic [31:0] pwdata, prdata, rd_w;
    logic [13:0] cpu_addr;
    logic io_cycle, io_strobe, io_out_bit, io_in_bit, io_space_enable_n, ext_io_in, tape_audio_in;
    logic user_port_select_n, system_port_select_n, serial_port_select_n, external_io_select;
    logic display_enable_n, shift_indicator, speaker_drive, tape_write_data;
    logic [5:1] user_int_n;
    logic [15:0] user_pin_in, user_pin_out, user_pin_oe;
    logic [3:0] user_led;
    logic [4:0] key_column_n;
    logic [8:0] key_row_n;
    logic [9:0] digit_enable_n, exp_dig;
    int error_cnt, num_checks;

    bio_top #(.FAILSAFE_CYCLES(FS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_addr(cpu_addr), .io_cycle(io_cycle), .io_strobe(io_strobe), .io_out_bit(io_out_bit),
        .io_in_bit(io_in_bit), .io_space_enable_n(io_space_enable_n), .user_port_select_n(user_port_select_n),
        .system_port_select_n(system_port_select_n), .serial_port_select_n(serial_port_select_n),
        .external_io_select(external_io_select), .ext_io_in(ext_io_in), .user_int_n(user_int_n),
        .user_pin_in(user_pin_in), .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe),
        .user_led(user_led), .key_column_n(key_column_n), .key_row_n(key_row_n),
        .digit_enable_n(digit_enable_n), .segment_drive(segment_drive), .display_enable_n(display_enable_n),
        .shift_indicator(shift_indicator), .speaker_drive(speaker_drive), .tape_write_data(tape_write_data),
        .tape_audio_in(tape_audio_in));
    bio_cpu_model cpu (.clk(pclk), .io_in_bit(io_in_bit), .cpu_addr(cpu_addr), .io_cycle(io_cycle),
        .io_strobe(io_strobe), .io_out_bit(io_out_bit));

    initial
    begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    // --------
    // tasks
    // --------
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1)
        begin
            chk("pready", 32'h1, pready);
            end_of_test();
        end
        rd_w = prdata;
        rd_e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    initial
    begin
        repeat (100000) @(posedge pclk);
        chk("watchdog", 32'h0, 32'h1);
        end_of_test();
    end
    // --------
    // sequence
    // --------
    initial
    begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_io_in, tape_audio_in, user_int_n, user_pin_in, key_column_n} = 28'hAD4B875;
        error_cnt = 0;
        num_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        chk("digit", 32'h3FF, digit_enable_n);
        chk("disp", 32'h1, display_enable_n);
        for (int k = 0; k < 4; k++)
        begin
            cpu.rd(12'(k << 10), b);
            chk("sel", {k != 0, k != 1, k != 2, k == 3}, {user_port_select_n,
                system_port_select_n, serial_port_select_n, external_io_select});
            chk("space", 32'h0, io_space_enable_n);
        end
        cpu.rd(12'h440, b);
        chk("gapsel", 32'hE, {user_port_select_n, system_port_select_n, serial_port_select_n, external_io_select});
        chk("gapspace", 32'h1, io_space_enable_n);
        chk("gapbit", 32'h0, b);
        for (int k = 0; k < 4; k++) cpu.wr(12'h020 + 12'(2 * k), 1'h1);
        chk("led", 32'hF, user_led);
        chk("oe", 32'hF, user_pin_oe[3:0]);
        cpu.wr(12'h022, 1'h0);
        chk("led", 32'hD, user_led);
        for (int k = 8; k < 10; k++)
        begin
            cpu.rd(12'h020 + 12'(2 * k), b);
            chk("pin", user_pin_in[k], b);
        end
        for (int k = 1; k < 6; k++)
        begin
            cpu.rd(12'(2 * k), b);
            chk("uint", user_int_n[k], b);
        end
        for (int c = 0; c < 16; c++)
        begin
            for (int k = 0; k < 4; k++) cpu.wr(12'h420 + 12'(2 * k), c[k]);
            exp_dig = (c < 10) ? ~(10'h001 << c) : 10'h3FF;
            chk("digit", exp_dig, digit_enable_n);
            chk("row", exp_dig[8:0], key_row_n);
        end
        cpu.wr(12'h428, 1'h0);
        chk("seg", 32'h0, segment_drive);
        cpu.wr(12'h438, 1'h0);
        chk("disp", 32'h0, display_enable_n);
        chk("seg", 32'h1, segment_drive);
        apb(bio_pkg::OFS_CTRL, 1'h1, 32'h1);
        apb(bio_pkg::OFS_STATUS, 1'h0, 32'h0);
        chk("blank", 32'h3, {rd_w[0], display_enable_n});
        apb(bio_pkg::OFS_CTRL, 1'h1, 32'h0);
        apb(bio_pkg::OFS_STATUS, 1'h0, 32'h0);
        chk("unblank", 32'h0, {rd_w[0], display_enable_n});
        repeat (FS + 8) @(posedge pclk);
        chk("expire", 32'h1, display_enable_n);
        chk("seg", 32'h0, segment_drive);
        cpu.wr(12'h438, 1'h1);
        cpu.wr(12'h438, 1'h0);
        chk("disp", 32'h0, display_enable_n);
        chk("aux", 32'h7, {shift_indicator, speaker_drive, tape_write_data});
        for (int k = 13; k < 16; k++)
        begin
            cpu.wr(12'h420 + 12'(2 * k), 1'h0);
            chk("aux", 32'h7 >> (k - 12), {shift_indicator, speaker_drive, tape_write_data});
        end
        for (int k = 1; k < 6; k++)
        begin
            cpu.rd(12'h400 + 12'(2 * k), b);
            chk("col", key_column_n[k - 1], b);
        end
        for (int t = 0; t < 2; t++)
        begin
            tape_audio_in <= t[0];
            cpu.rd(12'h40C, b);
            chk("tape", t[0], b);
        end
        apb(bio_pkg::OFS_STATUS, 1'h0, 32'h0);
        chk("status", {~key_column_n, 1'h1}, rd_w[8:3]);
        cpu.rd(12'hC00, b);
        chk("ext", ext_io_in, b);
        cpu.rd(12'h800, b);
        chk("ser", 32'h0, b);
        cpu.rd(12'h43C, b);
        apb(bio_pkg::OFS_IOADDR, 1'h0, 32'h0);
        chk("ioaddr", 32'h043C021E, rd_w & 32'h0FFF07FF);
        apb(8'h40, 1'h0, 32'h0);
        chk("slverr", 32'h1, rd_e);
        cpu.rel();
        end_of_test();
    end
endmodule
